// File: agf_regs_cfg.svh
// Register offsets, field positions and reset values for the amplifier/filter bank
`ifndef AGF_REGS_CFG_SVH
`define AGF_REGS_CFG_SVH
`define AGF_IDX_AMP          8'hC3
`define AGF_IDX_TERM         8'hC4
`define AGF_IDX_PWR          8'hC5
`define AGF_RST_REG          16'h0000
`define AGF_RST_PWR          2'h0
`define AGF_AMP_GAIN_BIT     13
`define AGF_AMP_CLAMP_BIT    7
`define AGF_AMP_CLVL_BIT     6
`define AGF_AMP_HPF_BIT      4
`define AGF_AMP_LPF_LSB      0
`define AGF_TERM_HPF_BIT     12
`define AGF_TERM_EN_BIT      8
`define AGF_TERM_GBL_LSB     6
`define AGF_TERM_IND_EN_BIT  5
`define AGF_TERM_IND_LSB     0
`define AGF_TERM_GAIN_LSB    13
`define AGF_LNA_GAIN_12DB    2'h2
`define AGF_PWR_MODE_INV     2'h0
`endif

// File: agf_pkg.sv
// Types for the amplifier/filter configuration bank
package agf_pkg;
   // Decoded low-pass cutoff, one-hot
   typedef enum logic [6:0] {
      AGF_LPF_15 = 7'h01,
      AGF_LPF_20 = 7'h02,
      AGF_LPF_35 = 7'h04,
      AGF_LPF_30 = 7'h08,
      AGF_LPF_50 = 7'h10,
      AGF_LPF_10 = 7'h20,
      AGF_LPF_NA = 7'h40
   } agf_lpf_t;
   // Decoded termination resistor, one-hot
   typedef enum logic [4:0] {
      AGF_TERM_50  = 5'h01,
      AGF_TERM_100 = 5'h02,
      AGF_TERM_200 = 5'h04,
      AGF_TERM_400 = 5'h08,
      AGF_TERM_HIZ = 5'h10
   } agf_term_t;
endpackage : agf_pkg

// File: agf_regs.sv
// AHB-Lite register bank for the amplifier and filter configuration of one path
// Summary of operation
// - Gain bit selects 24 dB or 30 dB
// - Clamp bit sense inverts in power mode 00
// - Clamp level bit selects -2 or 0 dBFS
// - Amp high-pass bypass: 1 switches filter out
// - Cutoff code maps to six filter cutoffs
// - All three registers reset zero, fully read/write
// - Input amp high-pass bypass: 1 disables filter
// - Termination enable bit turns termination on
// - Global code picks resistor, code 0 gives HiZ at 12 dB
// - Single resistor code acts only when enabled
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "agf_regs_cfg.svh"
module agf_regs
   import agf_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // Amplifier controls
   output var  logic        amp_gain_30db,
   output var  logic        amp_clamp_on,
   output var  logic        amp_clamp_at_0dbfs,
   output var  logic        amp_highpass_on,
   output var  agf_lpf_t    lowpass_cutoff,
   // Input amplifier and termination controls
   output var  logic        input_amp_highpass_on,
   output var  logic        termination_on,
   output var  agf_term_t   termination_value,
   output var  logic        single_resistor_on,
   output var  logic [4:0]  single_resistor_code
);

   logic [15:0] amp_cfg, next_amp_cfg;
   logic [15:0] term_cfg, next_term_cfg;
   logic [1:0]  power_mode_select, next_power_mode_select;
   logic        wr_pend, next_wr_pend;
   logic [7:0]  wr_idx, next_wr_idx;
   logic [31:0] next_hrdata;
   logic        next_amp_gain_30db, next_amp_clamp_on, next_amp_clamp_at_0dbfs;
   logic        next_amp_highpass_on, next_input_amp_highpass_on, next_termination_on;
   logic        next_single_resistor_on;
   logic [4:0]  next_single_resistor_code;
   agf_lpf_t    next_lowpass_cutoff;
   agf_term_t   next_termination_value;
   logic        access;
   logic [7:0]  a_idx;

   // Word index of a byte address
   function automatic logic [7:0] word_idx(input logic [31:0] addr);
      word_idx = addr[9:2];
   endfunction : word_idx

   // Read value of a register index, zero for unmapped
   function automatic logic [31:0] rd_val(input logic [7:0] idx, input logic [15:0] a,
                                          input logic [15:0] t, input logic [1:0] p);
      rd_val = 32'h0000_0000;
      if (idx == `AGF_IDX_AMP) begin
         rd_val = {16'h0000, a};
      end else if (idx == `AGF_IDX_TERM) begin
         rd_val = {16'h0000, t};
      end else if (idx == `AGF_IDX_PWR) begin
         rd_val = {30'h0000_0000, p};
      end
   endfunction : rd_val

   assign access = hsel && hready && htrans[1];
   assign a_idx  = word_idx(haddr);

   // Bus state: writes land one cycle after the address phase, zero wait
   always_comb begin
      next_wr_pend           = access && hwrite;
      next_wr_idx            = access ? a_idx : wr_idx;
      next_amp_cfg           = amp_cfg;
      next_term_cfg          = term_cfg;
      next_power_mode_select = power_mode_select;
      next_hrdata            = hrdata;
      if (wr_pend) begin
         if (wr_idx == `AGF_IDX_AMP) begin
            next_amp_cfg = hwdata[15:0];
         end else if (wr_idx == `AGF_IDX_TERM) begin
            next_term_cfg = hwdata[15:0];
         end else if (wr_idx == `AGF_IDX_PWR) begin
            next_power_mode_select = hwdata[1:0];
         end
      end
      if (access && !hwrite) begin
         next_hrdata = rd_val(a_idx, next_amp_cfg, next_term_cfg, next_power_mode_select);
      end
   end

   // Decoded controls
   always_comb begin
      next_amp_gain_30db = next_amp_cfg[`AGF_AMP_GAIN_BIT];
      if (next_power_mode_select == `AGF_PWR_MODE_INV) begin
         next_amp_clamp_on = !next_amp_cfg[`AGF_AMP_CLAMP_BIT];
      end else begin
         next_amp_clamp_on = next_amp_cfg[`AGF_AMP_CLAMP_BIT];
      end
      next_amp_clamp_at_0dbfs = next_amp_cfg[`AGF_AMP_CLVL_BIT];
      next_amp_highpass_on    = !next_amp_cfg[`AGF_AMP_HPF_BIT];
      unique case (next_amp_cfg[`AGF_AMP_LPF_LSB +: 4])
         4'h0:    next_lowpass_cutoff = AGF_LPF_15;
         4'h4:    next_lowpass_cutoff = AGF_LPF_20;
         4'h5:    next_lowpass_cutoff = AGF_LPF_35;
         4'h6:    next_lowpass_cutoff = AGF_LPF_30;
         4'h7:    next_lowpass_cutoff = AGF_LPF_50;
         4'h8:    next_lowpass_cutoff = AGF_LPF_10;
         default: next_lowpass_cutoff = AGF_LPF_NA;
      endcase
      next_input_amp_highpass_on = !next_term_cfg[`AGF_TERM_HPF_BIT];
      next_termination_on        = next_term_cfg[`AGF_TERM_EN_BIT];
      unique case (next_term_cfg[`AGF_TERM_GBL_LSB +: 2])
         2'h0: next_termination_value =
               (next_term_cfg[`AGF_TERM_GAIN_LSB +: 2] == `AGF_LNA_GAIN_12DB)
               ? AGF_TERM_HIZ : AGF_TERM_50;
         2'h1: next_termination_value = AGF_TERM_100;
         2'h2: next_termination_value = AGF_TERM_200;
         2'h3: next_termination_value = AGF_TERM_400;
      endcase
      next_single_resistor_on   = next_term_cfg[`AGF_TERM_IND_EN_BIT];
      next_single_resistor_code = next_single_resistor_on
                                  ? next_term_cfg[`AGF_TERM_IND_LSB +: 5] : 5'h00;
   end

   // Registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         amp_cfg               <= `AGF_RST_REG;
         term_cfg              <= `AGF_RST_REG;
         power_mode_select     <= `AGF_RST_PWR;
         wr_pend               <= 1'b0;
         wr_idx                <= 8'h00;
         hrdata                <= 32'h0000_0000;
         hreadyout             <= 1'b1;
         hresp                 <= 1'b0;
         amp_gain_30db         <= 1'b0;
         amp_clamp_on          <= 1'b1;
         amp_clamp_at_0dbfs    <= 1'b0;
         amp_highpass_on       <= 1'b1;
         lowpass_cutoff        <= AGF_LPF_15;
         input_amp_highpass_on <= 1'b1;
         termination_on        <= 1'b0;
         termination_value     <= AGF_TERM_50;
         single_resistor_on    <= 1'b0;
         single_resistor_code  <= 5'h00;
      end else begin
         amp_cfg               <= next_amp_cfg;
         term_cfg              <= next_term_cfg;
         power_mode_select     <= next_power_mode_select;
         wr_pend               <= next_wr_pend;
         wr_idx                <= next_wr_idx;
         hrdata                <= next_hrdata;
         hreadyout             <= 1'b1;
         hresp                 <= 1'b0;
         amp_gain_30db         <= next_amp_gain_30db;
         amp_clamp_on          <= next_amp_clamp_on;
         amp_clamp_at_0dbfs    <= next_amp_clamp_at_0dbfs;
         amp_highpass_on       <= next_amp_highpass_on;
         lowpass_cutoff        <= next_lowpass_cutoff;
         input_amp_highpass_on <= next_input_amp_highpass_on;
         termination_on        <= next_termination_on;
         termination_value     <= next_termination_value;
         single_resistor_on    <= next_single_resistor_on;
         single_resistor_code  <= next_single_resistor_code;
      end
   end

   // Checks
   property p_gain_follows;
      @(posedge clk_sys) disable iff (reset)
      ##1 amp_gain_30db == $past(next_amp_cfg[`AGF_AMP_GAIN_BIT]);
   endproperty
   a_gain_follows: assert property (p_gain_follows) else $error("gain mismatch");

   property p_clamp_sense;
      @(posedge clk_sys) disable iff (reset)
      amp_clamp_on == ((power_mode_select == `AGF_PWR_MODE_INV)
                       ^ amp_cfg[`AGF_AMP_CLAMP_BIT]);
   endproperty
   a_clamp_sense: assert property (p_clamp_sense) else $error("clamp sense wrong");

   property p_clamp_level;
      @(posedge clk_sys) disable iff (reset)
      1 |-> amp_clamp_at_0dbfs == amp_cfg[`AGF_AMP_CLVL_BIT];
   endproperty
   a_clamp_level: assert property (p_clamp_level) else $error("clamp level wrong");

   property p_hpf;
      @(posedge clk_sys) disable iff (reset)
      amp_highpass_on != amp_cfg[`AGF_AMP_HPF_BIT];
   endproperty
   a_hpf: assert property (p_hpf) else $error("amp high-pass wrong");

   property p_lpf_50;
      @(posedge clk_sys) disable iff (reset)
      (amp_cfg[3:0] == 4'h7) |-> (lowpass_cutoff == AGF_LPF_50);
   endproperty
   a_lpf_50: assert property (p_lpf_50) else $error("cutoff decode wrong");

   property p_write_lands;
      @(posedge clk_sys) disable iff (reset)
      (access && hwrite && a_idx == `AGF_IDX_AMP) ##1 1 |=> amp_cfg == $past(hwdata[15:0]);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write lost");

   property p_lna_hpf;
      @(posedge clk_sys) disable iff (reset)
      input_amp_highpass_on != term_cfg[`AGF_TERM_HPF_BIT];
   endproperty
   a_lna_hpf: assert property (p_lna_hpf) else $error("input high-pass wrong");

   property p_term_en;
      @(posedge clk_sys) disable iff (reset)
      termination_on == term_cfg[`AGF_TERM_EN_BIT];
   endproperty
   a_term_en: assert property (p_term_en) else $error("termination enable wrong");

   property p_hiz;
      @(posedge clk_sys) disable iff (reset)
      (term_cfg[7:6] == 2'h0 && term_cfg[14:13] == 2'h2) |-> termination_value == AGF_TERM_HIZ;
   endproperty
   a_hiz: assert property (p_hiz) else $error("high impedance missing");

   property p_ind_res;
      @(posedge clk_sys) disable iff (reset)
      !term_cfg[`AGF_TERM_IND_EN_BIT] |-> single_resistor_code == 5'h00;
   endproperty
   a_ind_res: assert property (p_ind_res) else $error("resistor code leaks");

   // Clamp is on with a cleared bit in the inverted mode
   property p_clamp_inv;
      @(posedge clk_sys) disable iff (reset)
      (power_mode_select == 2'h0 && !amp_cfg[`AGF_AMP_CLAMP_BIT]) |-> amp_clamp_on == 1'b1;
   endproperty
   a_clamp_inv: assert property (p_clamp_inv) else $error("clamp off in mode 00");

   // Every defined cutoff code reaches its own decode
   property p_lpf_15;
      @(posedge clk_sys) disable iff (reset)
      (amp_cfg[3:0] == 4'h0) |-> (lowpass_cutoff == AGF_LPF_15);
   endproperty
   a_lpf_15: assert property (p_lpf_15) else $error("cutoff 15 wrong");

   property p_lpf_20;
      @(posedge clk_sys) disable iff (reset)
      (amp_cfg[3:0] == 4'h4) |-> (lowpass_cutoff == AGF_LPF_20);
   endproperty
   a_lpf_20: assert property (p_lpf_20) else $error("cutoff 20 wrong");

   property p_lpf_35;
      @(posedge clk_sys) disable iff (reset)
      (amp_cfg[3:0] == 4'h5) |-> (lowpass_cutoff == AGF_LPF_35);
   endproperty
   a_lpf_35: assert property (p_lpf_35) else $error("cutoff 35 wrong");

   property p_lpf_30;
      @(posedge clk_sys) disable iff (reset)
      (amp_cfg[3:0] == 4'h6) |-> (lowpass_cutoff == AGF_LPF_30);
   endproperty
   a_lpf_30: assert property (p_lpf_30) else $error("cutoff 30 wrong");

   property p_lpf_10;
      @(posedge clk_sys) disable iff (reset)
      (amp_cfg[3:0] == 4'h8) |-> (lowpass_cutoff == AGF_LPF_10);
   endproperty
   a_lpf_10: assert property (p_lpf_10) else $error("cutoff 10 wrong");

   // Global termination codes away from the high impedance case
   property p_term_400;
      @(posedge clk_sys) disable iff (reset)
      (term_cfg[7:6] == 2'h3) |-> termination_value == AGF_TERM_400;
   endproperty
   a_term_400: assert property (p_term_400) else $error("400 ohm code wrong");

   property p_term_50;
      @(posedge clk_sys) disable iff (reset)
      (term_cfg[7:6] == 2'h0 && term_cfg[14:13] != 2'h2) |-> termination_value == AGF_TERM_50;
   endproperty
   a_term_50: assert property (p_term_50) else $error("50 ohm code wrong");

   // Single resistor enable and code pass through when enabled
   property p_ind_on;
      @(posedge clk_sys) disable iff (reset)
      single_resistor_on == term_cfg[`AGF_TERM_IND_EN_BIT];
   endproperty
   a_ind_on: assert property (p_ind_on) else $error("resistor enable wrong");

   property p_ind_pass;
      @(posedge clk_sys) disable iff (reset)
      term_cfg[`AGF_TERM_IND_EN_BIT] |-> single_resistor_code == term_cfg[4:0];
   endproperty
   a_ind_pass: assert property (p_ind_pass) else $error("resistor code lost");

   // Read data of the amplifier register stands in the data phase
   property p_read_amp;
      @(posedge clk_sys) disable iff (reset)
      (access && !hwrite && a_idx == `AGF_IDX_AMP) |=> hrdata == {16'h0000, amp_cfg};
   endproperty
   a_read_amp: assert property (p_read_amp) else $error("read data wrong");

   // Both registers are zero right after reset
   property p_reset_zero;
      @(posedge clk_sys) disable iff (reset)
      $past(reset) |-> (amp_cfg == `AGF_RST_REG && term_cfg == `AGF_RST_REG);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

endmodule : agf_regs
`default_nettype wire

// File: agf_regs_tb_top.sv
// Self-checking bench for the amplifier and filter register bank
`timescale 1ns/100ps
`default_nettype none
module agf_regs_tb_top;
   import agf_pkg::*;
   localparam logic [31:0] A_AMP  = 32'h0000030C;
   localparam logic [31:0] A_TERM = 32'h00000310;
   localparam logic [31:0] A_PWR  = 32'h00000314;
   localparam logic [31:0] A_NONE = 32'h00000318;
   logic        clk_sys = 1'b0;
   logic        reset   = 1'b1;
   logic        hsel    = 1'b0;
   logic        hwrite  = 1'b0;
   logic [1:0]  htrans  = 2'h0;
   logic [2:0]  hsize   = 3'h0;
   logic [31:0] haddr   = 32'h0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, amp_gain_30db, amp_clamp_on, amp_clamp_at_0dbfs;
   logic        amp_highpass_on, input_amp_highpass_on, termination_on, single_resistor_on;
   logic [4:0]  single_resistor_code;
   agf_lpf_t    lowpass_cutoff;
   agf_term_t   termination_value;
   int          err_total = 0;
   int          compares  = 0;

   // Clock at 20 MHz
   always #25 clk_sys = ~clk_sys;

   // Single slave, so its ready is the bus ready
   agf_regs uut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .amp_gain_30db(amp_gain_30db),
      .amp_clamp_on(amp_clamp_on), .amp_clamp_at_0dbfs(amp_clamp_at_0dbfs),
      .amp_highpass_on(amp_highpass_on), .lowpass_cutoff(lowpass_cutoff),
      .input_amp_highpass_on(input_amp_highpass_on), .termination_on(termination_on),
      .termination_value(termination_value), .single_resistor_on(single_resistor_on),
      .single_resistor_code(single_resistor_code));

   // Verdict and end of run
   task stop_test;
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   // One comparison
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Single AHB-Lite transfer; read data taken at the edge ending the data phase
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      int n;
      rd     = 32'h0000_0000;
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= 3'h2;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout === 1'b1) begin
         hsel   <= 1'b0;
         htrans <= 2'h0;
         hwdata <= wd;
         n = 0;
         do begin
            @(posedge clk_sys);
            n++;
         end while (hreadyout !== 1'b1 && n < 20);
         rd = hrdata;
      end
      if (hreadyout !== 1'b1) begin
         err_total++;
         $display("[ERR] hready expected 1 seen %b", hreadyout);
         stop_test();
      end
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
      // One more edge so the decoded outputs launched by the write are settled
      @(posedge clk_sys);
   endtask : wr

   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask : rdc

   // Reset and check every reset value
   task automatic t_reset;
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      chk("rst_out", 32'({4'b0101, 7'h01, 2'b10, 5'h01, 7'h00}), 32'({amp_gain_30db,
         amp_clamp_on, amp_clamp_at_0dbfs, amp_highpass_on, lowpass_cutoff,
         input_amp_highpass_on, termination_on, termination_value, single_resistor_on,
         single_resistor_code, hresp}));
      chk("rst_rdy", 32'h1, 32'(hreadyout));
      rdc("rst_amp", A_AMP, 32'h0);
      rdc("rst_term", A_TERM, 32'h0);
      rdc("rst_pwr", A_PWR, 32'h0);
   endtask : t_reset

   // Every defined cutoff code with gain, level and bypass varied
   task automatic t_amp;
      logic [3:0]  codes [7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h7};
      logic [6:0]  dec [7]   = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h10};
      logic [15:0] v;
      wr(A_PWR, 32'h1);
      for (int i = 0; i < 7; i++) begin
         v = {2'h0, i[0], 5'h00, i[1], i[2], 1'b0, ~i[0], codes[i]};
         wr(A_AMP, {16'h0, v});
         chk("gain", 32'(i[0]), 32'(amp_gain_30db));
         chk("clamp", 32'(i[1]), 32'(amp_clamp_on));
         chk("level", 32'(i[2]), 32'(amp_clamp_at_0dbfs));
         chk("amp_hpf", 32'(i[0]), 32'(amp_highpass_on));
         chk("lpf", 32'(dec[i]), 32'(lowpass_cutoff));
         rdc("amp", A_AMP, {16'h0, v});
      end
   endtask : t_amp

   // Clamp bit sense in power modes 00 to 10, level at the preferred 0 dBFS
   task automatic t_clamp;
      for (int m = 0; m < 3; m++) for (int b = 0; b < 2; b++) begin
         wr(A_PWR, 32'(m));
         wr(A_AMP, (32'(b) << 7) | 32'h0000_0040);
         chk("clamp_mode", (m == 0) ? 32'(b == 0) : 32'(b), 32'(amp_clamp_on));
         chk("level_top", 32'h1, 32'(amp_clamp_at_0dbfs));
      end
   endtask : t_clamp

   // Termination fields under input amp gain codes 0 to 2
   task automatic t_term;
      logic [15:0] v;
      logic [4:0]  e;
      for (int g = 0; g < 3; g++) for (int c = 0; c < 4; c++) begin
         v = {1'b0, 2'(g), c[1], 3'h0, c[0], 2'(c), g[0], 5'h15};
         e = (c == 0 && g == 2) ? 5'h10 : 5'(1 << c);
         wr(A_TERM, {16'h0, v});
         chk("in_hpf", 32'(!c[1]), 32'(input_amp_highpass_on));
         chk("term_on", 32'(c[0]), 32'(termination_on));
         chk("term_val", 32'(e), 32'(termination_value));
         chk("res_on", 32'(g[0]), 32'(single_resistor_on));
         chk("res_code", g[0] ? 32'h15 : 32'h0, 32'(single_resistor_code));
      end
      rdc("term", A_TERM, {16'h0, v});
   endtask : t_term

   // Used bits writable, upper half ignored, read right behind write, unmapped place empty
   task automatic t_bits;
      logic [31:0] r;
      bus(1'b1, A_AMP, 32'hABCD20D7, r);
      rdc("amp_all", A_AMP, 32'h000020D7);
      wr(A_NONE, 32'h0000FFFF);
      rdc("unmapped", A_NONE, 32'h0);
      wr(A_TERM, 32'h0000FFFF);
      rdc("term_all", A_TERM, 32'h0000FFFF);
   endtask : t_bits

   // Main sequence, ending with a second reset in mid-run
   initial begin
      t_reset();
      t_amp();
      t_clamp();
      t_term();
      t_bits();
      t_reset();
      stop_test();
   end
endmodule : agf_regs_tb_top
`default_nettype wire
